//--- logic/ptc_cycle_seq.sv
/*
 * Regulator power cycle sequencer: off for a fixed time, then restart.
 * Assumes start_i is a one-cycle pulse on sys_clk_i.
 */
`timescale 1ns/1ns
module ptc_cycle_seq import ptc_pkg::*; #(
    parameter int unsigned OFF_CYCLES = REG_OFF_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Request
    input  wire logic start_i,
    // Status
    output logic      busy_o,
    output logic      regs_off_o,
    output logic      restart_o
);

    ptc_seq_state_t         state;
    ptc_seq_state_t         next_state;
    logic [OFF_CNT_W-1:0]   cnt;
    logic [OFF_CNT_W-1:0]   next_cnt;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        // A new request restarts the off period from the beginning
        if (start_i) begin
            next_state = SEQ_OFF;
            next_cnt   = OFF_CNT_W'(OFF_CYCLES - 1);
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                end
                SEQ_OFF: begin
                    if (cnt == '0) begin
                        next_state = SEQ_RESTART;
                    end else begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                SEQ_RESTART: begin
                    next_state = SEQ_IDLE;
                end
                default: begin
                    next_state = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= SEQ_IDLE;
            cnt        <= '0;
            busy_o     <= 1'b0;
            regs_off_o <= 1'b0;
            restart_o  <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            busy_o     <= (next_state != SEQ_IDLE);
            regs_off_o <= (next_state == SEQ_OFF);
            restart_o  <= (next_state == SEQ_RESTART);
        end
    end

endmodule

//--- logic/ptc_i2c_slave.sv
/*
 * I2C slave with a register pointer: write pointer, then data bytes;
 * reads return the addressed register with auto increment.
 * Assumes SCL and SDA arrive asynchronously, SCL well below 5 MHz.
 */
`timescale 1ns/1ns
module ptc_i2c_slave import ptc_pkg::*; (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Serial pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Register access
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wr_data_o,
    input  wire logic [7:0] rd_data_i
);

    // ------------------------------------------------------------
    // Pin synchronisers, bit 0 is SCL, bit 1 is SDA
    // ------------------------------------------------------------
    logic [1:0] s1, s2, s3, filt, prev, next_filt;

    always_comb begin
        next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1   <= 2'h3;
            s2   <= 2'h3;
            s3   <= 2'h3;
            filt <= 2'h3;
            prev <= 2'h3;
        end else begin
            s1   <= {sda_i, scl_i};
            s2   <= s1;
            s3   <= s2;
            filt <= next_filt;
            prev <= filt;
        end
    end

    logic rise, fall, start_c, stop_c, sda;
    assign sda     = filt[1];
    assign rise    = filt[0] & ~prev[0];
    assign fall    = ~filt[0] & prev[0];
    assign start_c = filt[0] & prev[0] & prev[1] & ~filt[1];
    assign stop_c  = filt[0] & prev[0] & ~prev[1] & filt[1];

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    ptc_i2c_state_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh, next_ptr;
    logic       rw, next_rw, more, next_more, next_oe, next_wr;

    always_comb begin
        next_st   = st;
        next_cnt  = cnt;
        next_sh   = sh;
        next_ptr  = addr_o;
        next_rw   = rw;
        next_more = more;
        next_oe   = sda_oe_o;
        next_wr   = 1'b0;
        if (stop_c) begin
            next_st = I2C_IDLE;
            next_oe = 1'b0;
        end else if (start_c) begin
            next_st  = I2C_ADDR;
            next_cnt = '0;
            next_oe  = 1'b0;
        end else if (rise) begin
            if (st == I2C_ADDR || st == I2C_PTR || st == I2C_WDAT) begin
                next_sh  = {sh[6:0], sda};
                next_cnt = cnt + 1'b1;
            end else if (st == I2C_RDAT) begin
                next_cnt = cnt + 1'b1;
            end else if (st == I2C_RACK) begin
                // Master acknowledge asks for the next register
                next_more = ~sda;
                if (!sda) begin
                    next_ptr = addr_o + 1'b1;
                end
            end
        end else if (fall) begin
            unique case (st)
                I2C_IDLE: begin
                end
                I2C_ADDR: begin
                    if (cnt == BITS_PER_BYTE) begin
                        if (sh[7:1] == DEV_ADDR) begin
                            next_oe = 1'b1;
                            next_rw = sh[0];
                            next_st = I2C_ACK_A;
                        end else begin
                            next_st = I2C_IDLE;
                        end
                    end
                end
                I2C_ACK_A: begin
                    next_cnt = '0;
                    if (rw) begin
                        next_sh = rd_data_i;
                        next_oe = ~rd_data_i[7];
                        next_st = I2C_RDAT;
                    end else begin
                        next_oe = 1'b0;
                        next_st = I2C_PTR;
                    end
                end
                I2C_PTR: begin
                    if (cnt == BITS_PER_BYTE) begin
                        next_ptr = sh;
                        next_oe  = 1'b1;
                        next_st  = I2C_ACK_P;
                    end
                end
                I2C_ACK_P, I2C_ACK_W: begin
                    next_oe  = 1'b0;
                    next_cnt = '0;
                    next_st  = I2C_WDAT;
                    if (st == I2C_ACK_W) begin
                        next_ptr = addr_o + 1'b1;
                    end
                end
                I2C_WDAT: begin
                    if (cnt == BITS_PER_BYTE) begin
                        next_wr = 1'b1;
                        next_oe = 1'b1;
                        next_st = I2C_ACK_W;
                    end
                end
                I2C_RDAT: begin
                    if (cnt == BITS_PER_BYTE) begin
                        next_oe = 1'b0;
                        next_st = I2C_RACK;
                    end else begin
                        next_sh = {sh[6:0], 1'b0};
                        next_oe = ~sh[6];
                    end
                end
                I2C_RACK: begin
                    next_cnt = '0;
                    if (more) begin
                        next_sh = rd_data_i;
                        next_oe = ~rd_data_i[7];
                        next_st = I2C_RDAT;
                    end else begin
                        next_st = I2C_IDLE;
                    end
                end
                default: begin
                    next_st = I2C_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st        <= I2C_IDLE;
            cnt       <= '0;
            sh        <= '0;
            addr_o    <= '0;
            rw        <= 1'b0;
            more      <= 1'b0;
            sda_oe_o  <= 1'b0;
            sda_o     <= 1'b0;
            wr_o      <= 1'b0;
            wr_data_o <= '0;
        end else begin
            st        <= next_st;
            cnt       <= next_cnt;
            sh        <= next_sh;
            addr_o    <= next_ptr;
            rw        <= next_rw;
            more      <= next_more;
            sda_oe_o  <= next_oe;
            sda_o     <= 1'b0;
            wr_o      <= next_wr;
            wr_data_o <= sh;
        end
    end

endmodule

//--- logic/ptc_pkg.sv
/*
 * Shared constants and types of the top-level control register block.
 * Assumes a single 20 MHz system clock and an I2C register port.
 */
package ptc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTL2     = 8'h0B;
    localparam logic [7:0] ADDR_CTL3     = 8'h0C;
    localparam logic [7:0] CTL2_RESET    = 8'hCE;
    localparam logic [7:0] CTL3_RESET    = 8'h01;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LOCK_HI     = 7;
    localparam int LOCK_LO     = 6;
    localparam int TERM_BIT    = 5;
    localparam int SHUTDOWN_TEMPERATURE_HI    = 4;
    localparam int SHUTDOWN_TEMPERATURE_LO    = 2;
    localparam int WARN_HI     = 1;
    localparam int WARN_LO     = 0;
    localparam int RSVD_HI     = 7;
    localparam int RSVD_LO     = 5;
    localparam int MODE_HI_BIT = 4;
    localparam int MODE_LO_BIT = 3;
    localparam int SRST_BIT    = 2;
    localparam int GLT_HI      = 1;
    localparam int GLT_LO      = 0;

    // ------------------------------------------------------------
    // Serial port and timing
    // ------------------------------------------------------------
    // Slave address value is arbitrary
    localparam logic [6:0] DEV_ADDR      = 7'h2A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int unsigned SYS_CLK_HZ      = 20_000_000;
    localparam int unsigned REG_OFF_TIME_US = 1000;
    localparam int unsigned REG_OFF_CYCLES  =
        REG_OFF_TIME_US * (SYS_CLK_HZ / 1_000_000);
    localparam int OFF_CNT_W = 16;

    typedef enum logic [3:0] {
        I2C_IDLE  = 4'h0,
        I2C_ADDR  = 4'h1,
        I2C_ACK_A = 4'h2,
        I2C_PTR   = 4'h3,
        I2C_ACK_P = 4'h4,
        I2C_WDAT  = 4'h5,
        I2C_ACK_W = 4'h6,
        I2C_RDAT  = 4'h7,
        I2C_RACK  = 4'h8
    } ptc_i2c_state_t;

    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'h0,
        SEQ_OFF     = 2'h1,
        SEQ_RESTART = 2'h2
    } ptc_seq_state_t;

endpackage

//--- logic/ptc_top.sv
/*
 * Top-level control registers two and three of a power management chip:
 * thermal and charge configuration, operating mode, software reset.
 * Assumes the mode pins and I2C pins are asynchronous, and the pin mode
 * select enable comes from logic on sys_clk_i.
 */
// Summary of operation
// RQ1: Bit 5 of control two disables charge termination, reset value 0.
// RQ2: Non-terminating charge mode holds the fast charge timer in reset.
// RQ3: Bits 4:2 of control two: shutdown threshold code, reset 011.
// RQ4: Bits 1:0 of control two: die warning threshold code, reset 10.
// RQ5: Control three is read/write; bits 7:5 reserved, reset 0.
// RQ6: Mode comes from register bits or mode pins, per pin select enable.
// RQ7: Pin select off: register bits 4 and 3 give modes 0 to 3.
// RQ8: Writing 1 to reset bit 2 restores all other bits to defaults.
// RQ9: That write also turns regulators off and restarts them.
// RQ10: Reset bit clears itself once the reset has been acted on.
// RQ11: Control two sits at 0Bh; bits 7:6 lockout threshold, reset 11.
// RQ12: Reset bit reads 0 when idle; writing 0 to it does nothing.
`timescale 1ns/1ns
module ptc_top import ptc_pkg::*; #(
    parameter int unsigned OFF_CYCLES = REG_OFF_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // I2C pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Mode selection
    input  wire logic       pin_mode_select_enable_i,
    input  wire logic       mode_pin_hi_i,
    input  wire logic       mode_pin_lo_i,
    output logic [1:0]      op_mode_o,
    // Charger and thermal settings
    output logic            charge_termination_disable_o,
    output logic            charge_timer_reset_o,
    output logic [2:0]      thermal_shutdown_threshold_o,
    output logic [1:0]      die_temp_warning_o,
    output logic [1:0]      supply_lockout_threshold_o,
    output logic [1:0]      glitch_timer_sel_o,
    // Regulator cycling
    output logic            regulators_off_o,
    output logic            regulators_restart_o
);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    ptc_i2c_slave u_i2c (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oe_o  (sda_oe_o),
        .wr_o      (wr),
        .addr_o    (addr),
        .wr_data_o (wr_data),
        .rd_data_i (rd_data)
    );

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] top_control_two, next_ctl2;
    logic [7:0] top_control_three, next_ctl3;
    logic       soft_reset_bit;
    logic       srst_start;
    logic       seq_busy;

    assign soft_reset_bit = wr && addr == ADDR_CTL3 && wr_data[SRST_BIT];

    always_comb begin
        next_ctl2  = top_control_two;
        next_ctl3  = top_control_three;
        srst_start = 1'b0;
        if (soft_reset_bit) begin
            // Software reset overrides the rest of the written byte
            next_ctl2  = CTL2_RESET; // RQ8
            next_ctl3  = CTL3_RESET; // RQ8
            srst_start = 1'b1; // RQ9
        end else if (wr && addr == ADDR_CTL2) begin
            next_ctl2 = wr_data; // RQ1 RQ3 RQ4 RQ11
        end else if (wr && addr == ADDR_CTL3) begin
            // Reset bit is never stored, so a 0 write is a no-op
            next_ctl3 = wr_data; // RQ5 RQ7 RQ12
            next_ctl3[SRST_BIT] = 1'b0; // RQ12
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            top_control_two   <= CTL2_RESET;
            top_control_three <= CTL3_RESET;
        end else begin
            top_control_two   <= next_ctl2;
            top_control_three <= next_ctl3;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rd_data = READ_UNMAPPED;
        if (addr == ADDR_CTL2) begin
            rd_data = top_control_two; // RQ11
        end else if (addr == ADDR_CTL3) begin
            rd_data = top_control_three;
            rd_data[SRST_BIT] = seq_busy; // RQ10 RQ12
        end
    end

    // ------------------------------------------------------------
    // Regulator cycling
    // ------------------------------------------------------------
    ptc_cycle_seq #(
        .OFF_CYCLES (OFF_CYCLES)
    ) u_seq (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .start_i    (srst_start),
        .busy_o     (seq_busy),
        .regs_off_o (regulators_off_o),
        .restart_o  (regulators_restart_o)
    );

    // ------------------------------------------------------------
    // Mode pins and mode selection
    // ------------------------------------------------------------
    logic [1:0] mp1, mp2, mp3, mode_pins, next_mode_pins;
    logic [1:0] next_mode;

    always_comb begin
        // A pin level counts only once the second and third stages agree
        next_mode_pins = ((mp2 ~^ mp3) & mp3) | ((mp2 ^ mp3) & mode_pins);
        if (pin_mode_select_enable_i) begin
            next_mode = mode_pins; // RQ6
        end else begin
            next_mode = {top_control_three[MODE_HI_BIT],
                         top_control_three[MODE_LO_BIT]}; // RQ7
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mp1       <= 2'h0;
            mp2       <= 2'h0;
            mp3       <= 2'h0;
            mode_pins <= 2'h0;
            op_mode_o <= 2'h0;
        end else begin
            mp1       <= {mode_pin_hi_i, mode_pin_lo_i};
            mp2       <= mp1;
            mp3       <= mp2;
            mode_pins <= next_mode_pins;
            op_mode_o <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------
    assign charge_termination_disable_o = top_control_two[TERM_BIT]; // RQ1
    // Timer stays held for as long as termination is disabled
    assign charge_timer_reset_o = top_control_two[TERM_BIT]; // RQ2
    assign thermal_shutdown_threshold_o =
        top_control_two[SHUTDOWN_TEMPERATURE_HI:SHUTDOWN_TEMPERATURE_LO]; // RQ3
    assign die_temp_warning_o = top_control_two[WARN_HI:WARN_LO]; // RQ4
    assign supply_lockout_threshold_o =
        top_control_two[LOCK_HI:LOCK_LO]; // RQ11
    assign glitch_timer_sel_o = top_control_three[GLT_HI:GLT_LO]; // RQ5

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ctl2_wr;
        wr && addr == ADDR_CTL2;
    endsequence

    sequence s_srst_wr;
        soft_reset_bit;
    endsequence

    sequence s_cycle_start;
        s_srst_wr ##1 seq_busy;
    endsequence

    a_term_bit_write: // RQ1
        assert property (s_ctl2_wr |=> charge_termination_disable_o
                         == $past(wr_data[TERM_BIT]))
        else $error("termination bit not written");

    a_timer_reset_hold: // RQ2
        assert property (s_ctl2_wr ##0 wr_data[TERM_BIT] |=>
                         charge_timer_reset_o [*2])
        else $error("fast charge timer not held in reset");

    a_shutdown_code_write: // RQ3
        assert property (s_ctl2_wr |=> thermal_shutdown_threshold_o
                         == $past(wr_data[SHUTDOWN_TEMPERATURE_HI:SHUTDOWN_TEMPERATURE_LO]))
        else $error("shutdown threshold not written");

    a_warning_code_write: // RQ4
        assert property (s_ctl2_wr |=> die_temp_warning_o
                         == $past(wr_data[WARN_HI:WARN_LO]))
        else $error("warning threshold not written");

    a_ctl3_rsvd_write: // RQ5
        assert property (wr && addr == ADDR_CTL3 && !wr_data[SRST_BIT]
                         |=> top_control_three[RSVD_HI:RSVD_LO]
                         == $past(wr_data[RSVD_HI:RSVD_LO]))
        else $error("reserved bits not read/write");

    a_mode_from_pins: // RQ6
        assert property (pin_mode_select_enable_i |=>
                         op_mode_o == $past(mode_pins))
        else $error("mode not taken from pins");

    a_mode_from_regs: // RQ7
        assert property (!pin_mode_select_enable_i |=>
                         op_mode_o == $past({top_control_three[MODE_HI_BIT],
                                             top_control_three[MODE_LO_BIT]}))
        else $error("mode not taken from register bits");

    a_srst_defaults: // RQ8
        assert property (s_srst_wr |=> top_control_two == CTL2_RESET
                         && top_control_three == CTL3_RESET)
        else $error("software reset did not restore defaults");

    a_srst_cycle_regs: // RQ9
        assert property (s_cycle_start |-> regulators_off_o
                         && !regulators_restart_o)
        else $error("regulators not turned off by software reset");

    sequence s_cycle_end;
        regulators_restart_o && !soft_reset_bit;
    endsequence

    a_srst_self_clear: // RQ10
        assert property (s_cycle_end |=> !seq_busy)
        else $error("reset bit did not clear itself");

    a_lockout_write: // RQ11
        assert property (s_ctl2_wr |=> supply_lockout_threshold_o
                         == $past(wr_data[LOCK_HI:LOCK_LO]))
        else $error("lockout threshold not written");

    a_srst_zero_noop: // RQ12
        assert property (wr && addr == ADDR_CTL3 && !wr_data[SRST_BIT]
                         && !seq_busy |=> !seq_busy && !regulators_off_o)
        else $error("writing 0 to reset bit had an effect");

    a_off_then_restart: // RQ9
        assert property ($fell(regulators_off_o) |-> regulators_restart_o)
        else $error("regulators not restarted after off period");

    a_ctl2_hold: // RQ11
        assert property (!(wr && addr == ADDR_CTL2) && !soft_reset_bit
                         |=> $stable(top_control_two))
        else $error("control two changed without a write");

    a_ctl3_hold: // RQ5
        assert property (!(wr && addr == ADDR_CTL3)
                         |=> $stable(top_control_three))
        else $error("control three changed without a write");

    // Helper: length of the running off period, restarted by a new request
    logic [OFF_CNT_W-1:0] off_run;
    logic [OFF_CNT_W-1:0] next_off_run;

    always_comb begin
        next_off_run = '0;
        if (regulators_off_o && !srst_start) begin
            next_off_run = off_run + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            off_run <= '0;
        end else begin
            off_run <= next_off_run;
        end
    end

    a_off_length: // RQ9
        assert property ($fell(regulators_off_o) |->
                         off_run == OFF_CNT_W'(OFF_CYCLES))
        else $error("regulators off for the wrong time");

endmodule

//--- test/pmic_top_control_regs_bench.sv
/*
 * Self-checking bench for the top-level control registers two and three.
 * Assumes the bench is the only I2C master and SDA has a pull-up.
 */
`timescale 1ns/1ns
module pmic_top_control_regs_bench import ptc_pkg::*;;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int OFF_N = 16;
    logic       sys_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       scl     = 1'b1;
    logic       sda_m   = 1'b1;
    logic       pin_en  = 1'b0;
    logic       mp_hi   = 1'b0;
    logic       mp_lo   = 1'b0;
    logic       sda_w;
    logic       sda_o, sda_oe_o, term_o, timer_o, off_o, restart_o;
    logic [1:0] op_mode_o, warn_o, lock_o, glitch_o;
    logic [2:0] shutdown_temperature_o;
    logic [7:0] q;
    int         mismatches = 0;
    int         comparisons = 0;
    int         restarts = 0;
    int         off_cycles = 0;

    // Open drain: released line floats high through the pull-up
    assign sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (restart_o === 1'b1) restarts++;
        if (off_o === 1'b1) off_cycles++;
    end

    ptc_top #(.OFF_CYCLES(OFF_N)) dut_u (
        .sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .pin_mode_select_enable_i(pin_en), .mode_pin_hi_i(mp_hi),
        .mode_pin_lo_i(mp_lo), .op_mode_o(op_mode_o),
        .charge_termination_disable_o(term_o),
        .charge_timer_reset_o(timer_o),
        .thermal_shutdown_threshold_o(shutdown_temperature_o),
        .die_temp_warning_o(warn_o), .supply_lockout_threshold_o(lock_o),
        .glitch_timer_sel_o(glitch_o), .regulators_off_o(off_o),
        .regulators_restart_o(restart_o));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m = b; tick(6); scl = 1'b1; tick(12);
        r = sda_w; scl = 1'b0; tick(6);
    endtask
    task automatic start();
        sda_m = 1'b1; tick(6); scl = 1'b1; tick(6);
        sda_m = 1'b0; tick(6); scl = 1'b0; tick(6);
    endtask
    task automatic stop();
        sda_m = 1'b0; tick(6); scl = 1'b1; tick(6); sda_m = 1'b1; tick(12);
    endtask
    // Bit m set: the slave must acknowledge; master releases bit 9
    task automatic xfer(input logic [7:0] d, input logic m,
                        output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, a);
        if (m) check("ack", {7'h0, a}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        start(); xfer({DEV_ADDR, 1'b0}, 1'b1, r);
        xfer(p, 1'b1, r); xfer(d, 1'b1, r); stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] r;
        start(); xfer({DEV_ADDR, 1'b0}, 1'b1, r); xfer(p, 1'b1, r);
        start(); xfer({DEV_ADDR, 1'b1}, 1'b1, r); xfer(8'hFF, 1'b0, d);
        stop();
    endtask
    function automatic logic [7:0] ctl2_out();
        return {lock_o, term_o, shutdown_temperature_o, warn_o};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_defaults();
        check("ctl2 pins", ctl2_out(), 8'hCE);
        check("glitch", {6'h0, glitch_o}, 8'h01);
        rd(ADDR_CTL2, q); check("ctl2", q, 8'hCE);
        rd(ADDR_CTL3, q); check("ctl3", q, 8'h01);
        rd(8'h20, q); check("unmapped", q, 8'h00);
        $display("test defaults done");
    endtask
    task automatic test_ctl2();
        logic [7:0] v [3] = '{8'h3F, 8'hA4, 8'h5B};
        foreach (v[i]) begin
            wr(ADDR_CTL2, v[i]);
            check("ctl2 pins", ctl2_out(), v[i]);
            check("timer", {7'h0, timer_o}, {7'h0, v[i][5]});
            rd(ADDR_CTL2, q); check("ctl2", q, v[i]);
        end
        $display("test ctl2 done");
    endtask
    task automatic test_mode();
        for (int m = 0; m < 4; m++) begin
            pin_en = 1'b0;
            wr(ADDR_CTL3, 8'hA1 | 8'(m << 3));
            check("mode reg", {6'h0, op_mode_o}, 8'(m));
            rd(ADDR_CTL3, q); check("ctl3", q, 8'hA1 | 8'(m << 3));
            {mp_hi, mp_lo} = 2'(3 - m); pin_en = 1'b1; tick(8);
            check("mode pin", {6'h0, op_mode_o}, 8'(3 - m));
        end
        pin_en = 1'b0; tick(3);
        check("mode back", {6'h0, op_mode_o}, 8'h03);
        $display("test mode done");
    endtask
    task automatic test_soft_reset();
        wr(ADDR_CTL2, 8'h00);
        restarts = 0; off_cycles = 0;
        wr(ADDR_CTL3, 8'hFC);
        check("restarts", 8'(restarts), 8'h01);
        check("off time", 8'(off_cycles), 8'(OFF_N));
        check("ctl2 pins", ctl2_out(), 8'hCE);
        check("glitch", {6'h0, glitch_o}, 8'h01);
        rd(ADDR_CTL2, q); check("ctl2", q, 8'hCE);
        rd(ADDR_CTL3, q); check("ctl3", q, 8'h01);
        $display("test soft reset done");
    endtask

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        tick(20); rst = 1'b0; tick(6);
        test_defaults();
        test_ctl2();
        test_mode();
        test_soft_reset();
        complete_run();
    end
    // Whole run needs about 18k cycles
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        complete_run();
    end
endmodule
